// ===== logic/calendar_rtc_register_core.sv
// Calendar clock core: prescaler, calendar, alarm, capture, shift and registers
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "rtc_regs.svh"

module calendar_rtc_register_core
	import rtc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [31:0] rdata,
	// Pins
	input  wire logic        capture_pin,
	input  wire logic        tamper_pin,
	output logic             calibration_output_pin,
	output logic             alarm_out,
	output logic             capture_irq
);

	rtc_state_t st;
	rtc_state_t nx;

	logic       unlocked;
	logic       bypass;
	logic       apre_tick;
	logic       sec_tick;
	logic       shift_now;
	logic       ts_evt;
	logic       tp_evt;
	logic       alarm_hit;
	logic       carry_m;
	logic       carry_h;
	logic       carry_d;
	logic [7:0] hr_v;
	logic [7:0] day_v;
	logic [7:0] sec_v;
	logic [7:0] min_v;
	logic [31:0] rd_v;

	// One BCD step with wrap to zero at top
	function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top);
		if (v == top)
			return 8'h00;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return v + 8'h01;
	endfunction

	// One BCD step down
	function automatic logic [7:0] bcd_dec(input logic [7:0] v);
		if (v[3:0] == 4'h0)
			return {v[7:4] - 4'h1, 4'h9};
		else
			return v - 8'h01;
	endfunction

	// Reset image of the whole state
	function automatic rtc_state_t rst_state();
		rtc_state_t s;
		s = '0;
		s.psc = `PSC_RST;
		s.date_v = `DATE_RST;
		s.sh_date = `DATE_RST;
		s.apre_cnt = s.psc[22:16];
		s.sub = 16'h00FF;
		s.alarm_wr = 1'b1;
		s.key = KEY_LOCKED;
		return s;
	endfunction

	assign unlocked = (st.key == KEY_OPEN);
	assign bypass   = st.ctrl[`CT_BYPASS];

	// Alarm comparison against live calendar with per field masks
	always_comb begin
		alarm_hit = 1'b1;
		if (!st.alarm[`AL_SEC_IGN] && st.alarm[6:0] != st.time_v[6:0])
			alarm_hit = 1'b0;
		if (!st.alarm[`AL_MIN_IGN] && st.alarm[14:8] != st.time_v[14:8])
			alarm_hit = 1'b0;
		if (!st.alarm[`AL_HR_IGN] && st.alarm[22:16] != st.time_v[22:16])
			alarm_hit = 1'b0;
		if (!st.alarm[`AL_DAY_IGN]) begin
			if (st.alarm[`AL_WDAY_SEL]) begin
				if (st.alarm[27:24] != {1'b0, st.date_v[15:13]})
					alarm_hit = 1'b0;
			end else if (st.alarm[29:24] != st.date_v[5:0]) begin
				alarm_hit = 1'b0;
			end
		end
	end

	// Register read multiplexer
	always_comb begin
		rd_v = 32'h00000000;
		case (addr)
			`OFS_TIME:  rd_v = {9'h000, bypass ? st.time_v : st.sh_time};
			`OFS_DATE:  rd_v = {8'h00, bypass ? st.date_v : st.sh_date};
			`OFS_CTRL:  rd_v = st.ctrl;
			`OFS_STS:   rd_v = {15'h0000, st.cal_pend, 2'b00, st.tamp_flag, st.cap_ovr,
			                    st.cap_flag, 2'b00, st.alarm_flag, st.init_req, st.init_act,
			                    st.sh_sync, st.cal_set, st.adj_pend, 2'b11, st.alarm_wr};
			`OFS_PSC:   rd_v = {9'h000, st.psc};
			`OFS_ALARM: rd_v = st.alarm;
			`OFS_KEY:   rd_v = 32'h00000000;
			`OFS_FRAC:  rd_v = {16'h0000, bypass ? st.sub : st.sh_sub};
			`OFS_SHIFT: rd_v = 32'h00000000;
			`OFS_CAPT:  rd_v = {9'h000, st.cap_time};
			`OFS_CAL:   rd_v = {16'h0000, st.cal};
			default:    rd_v = 32'h00000000;
		endcase
	end

	// Next state
	always_comb begin
		nx = st;
		apre_tick = 1'b0;
		sec_tick  = 1'b0;
		shift_now = 1'b0;
		carry_m   = 1'b0;
		carry_h   = 1'b0;
		carry_d   = 1'b0;
		hr_v      = {2'b00, st.time_v[21:16]};
		day_v     = {2'b00, st.date_v[5:0]};
		sec_v     = 8'h00;
		min_v     = 8'h00;

		// Pin synchronisers, a change counts once stages two and three agree
		nx.ts_sync = {st.ts_sync[1:0], capture_pin};
		nx.tp_sync = {st.tp_sync[1:0], tamper_pin};
		if (st.ts_sync[1] == st.ts_sync[2])
			nx.ts_lvl = st.ts_sync[2];
		if (st.tp_sync[1] == st.tp_sync[2])
			nx.tp_lvl = st.tp_sync[2];
		ts_evt = st.ctrl[`CT_TS_EN] && (nx.ts_lvl != st.ts_lvl)
		         && (nx.ts_lvl != st.ctrl[`CT_EDGE]);
		tp_evt = nx.tp_lvl && !st.tp_lvl;

		// Two stage prescaler, held at reload in init mode
		if (st.init_req) begin
			nx.apre_cnt = st.psc[22:16];
			nx.sub = {1'b0, st.psc[14:0]};
		end else if (st.apre_cnt == 7'h00) begin
			nx.apre_cnt = st.psc[22:16];
			apre_tick = 1'b1;
		end else begin
			nx.apre_cnt = st.apre_cnt - 7'h01;
		end
		if (apre_tick) begin
			if (st.sub == 16'h0000) begin
				nx.sub = {1'b0, st.psc[14:0]};
				sec_tick = 1'b1;
			end else if (st.adj_pend) begin
				nx.sub = st.sub - 16'h0001 + {1'b0, st.shift_amt};
				sec_tick = st.shift_plus;
				shift_now = 1'b1;
			end else begin
				nx.sub = st.sub - 16'h0001;
			end
		end

		// Calendar advance and hour steps on the seconds tick
		if (sec_tick) begin
			carry_m = (st.time_v[6:0] == 7'h59);
			carry_h = carry_m && (st.time_v[14:8] == 7'h59);
			carry_d = carry_h && (st.time_v[21:16] == 6'h23);
			sec_v = bcd_step({1'b0, st.time_v[6:0]}, 8'h59);
			nx.time_v[6:0] = sec_v[6:0];
			if (carry_m) begin
				min_v = bcd_step({1'b0, st.time_v[14:8]}, 8'h59);
				nx.time_v[14:8] = min_v[6:0];
			end
			if (carry_h)
				hr_v = bcd_step(hr_v, 8'h23);
			if (st.fwd_pend)
				hr_v = bcd_step(hr_v, 8'h23);
			else if (st.bwd_pend && hr_v != 8'h00)
				hr_v = bcd_dec(hr_v);
			nx.time_v[21:16] = hr_v[5:0];
			nx.fwd_pend = 1'b0;
			nx.bwd_pend = 1'b0;
			if (carry_d) begin
				day_v = (day_v == 8'h31) ? 8'h01 : bcd_step(day_v, 8'h31);
				nx.date_v[5:0] = day_v[5:0];
				nx.date_v[15:13] = (st.date_v[15:13] == 3'h7) ? 3'h1 :
				                   st.date_v[15:13] + 3'h1;
			end
			nx.cal_pend = 1'b0;
		end

		// Hardware maintained status
		nx.init_act = st.init_req;
		nx.alarm_wr = !st.ctrl[`CT_ALR_EN] && !st.init_req;
		nx.cal_set  = (st.date_v[23:16] != 8'h00);
		if (shift_now)
			nx.adj_pend = 1'b0;
		nx.al_prev = alarm_hit;

		// Bus writes
		if (wr_stb) begin
			case (addr)
				`OFS_TIME: begin
					if (unlocked && st.init_act)
						nx.time_v = wdata[22:0] & `TIME_MASK;
				end
				`OFS_DATE: begin
					if (unlocked && st.init_act)
						nx.date_v = wdata[23:0] & `DATE_MASK;
				end
				`OFS_CTRL: begin
					if (unlocked) begin
						nx.ctrl = (wdata & `CT_WMASK & ~`CT_INIT_ONLY) |
						          ((st.init_act ? wdata : st.ctrl) & `CT_INIT_ONLY);
						if (!st.init_req) begin
							nx.fwd_pend = st.fwd_pend | wdata[`CT_FWD];
							nx.bwd_pend = st.bwd_pend | wdata[`CT_BWD];
						end
					end
				end
				`OFS_STS: begin
					if (!wdata[`ST_ALARM])
						nx.alarm_flag = 1'b0;
					if (!wdata[`ST_CAP])
						nx.cap_flag = 1'b0;
					if (!wdata[`ST_OVR])
						nx.cap_ovr = 1'b0;
					if (!wdata[`ST_TAMP])
						nx.tamp_flag = 1'b0;
					if (unlocked) begin
						nx.init_req = wdata[`ST_INIT_REQ];
						if (!wdata[`ST_SYNC])
							nx.sh_sync = 1'b0;
					end
				end
				`OFS_PSC: begin
					if (unlocked && st.init_act)
						nx.psc = wdata[22:0] & `PSC_MASK;
				end
				`OFS_ALARM: begin
					if (unlocked && (st.alarm_wr || st.init_act))
						nx.alarm = wdata;
				end
				`OFS_KEY: begin
					case (st.key)
						KEY_LOCKED: nx.key = (wdata[7:0] == `KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
						KEY_HALF:   nx.key = (wdata[7:0] == `KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
						KEY_OPEN:   nx.key = KEY_LOCKED;
						default:    nx.key = KEY_LOCKED;
					endcase
				end
				`OFS_SHIFT: begin
					if (unlocked && !st.adj_pend) begin
						nx.shift_amt  = wdata[14:0];
						nx.shift_plus = wdata[31];
						nx.adj_pend   = 1'b1;
						nx.sh_sync    = 1'b0;
					end
				end
				`OFS_CAL: begin
					if (unlocked && !st.cal_pend) begin
						nx.cal = wdata[15:0];
						nx.cal_pend = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end

		// Shadow copies every two cycles unless a shift is pending, also in init so loaded values read back;
		// flag held clear while a shift is pending, bypassed or in init
		nx.half = ~st.half;
		if (st.adj_pend || bypass || st.init_req) begin
			nx.sh_sync = 1'b0;
		end
		if (st.half && !st.adj_pend) begin
			nx.sh_time = st.time_v;
			nx.sh_date = st.date_v;
			nx.sh_sub  = st.sub;
			if (!bypass && !st.init_req)
				nx.sh_sync = 1'b1;
		end

		// Hardware event sets win over software clears
		if (st.ctrl[`CT_ALR_EN] && alarm_hit && !st.al_prev && !st.init_req)
			nx.alarm_flag = 1'b1;
		if (ts_evt) begin
			if (st.cap_flag)
				nx.cap_ovr = 1'b1;
			nx.cap_flag = 1'b1;
			nx.cap_time = st.time_v;
		end
		if (tp_evt)
			nx.tamp_flag = 1'b1;
		if (!nx.cap_flag)
			nx.cap_time = 23'h000000;

		// Registered outputs
		nx.rdata = rd_stb ? rd_v : 32'h00000000;
		nx.cal_out = st.ctrl[`CT_CAL_EN] &
		             (st.ctrl[`CT_RATE] ? st.sub[7] : st.apre_cnt[5]);
		nx.alarm_out = ((st.ctrl[`CT_SRC_HI:`CT_SRC_LO] == `ALARM_SRC_A) && st.alarm_flag)
		               ^ st.ctrl[`CT_POL];
		nx.irq = st.ctrl[`CT_CAP_IE] & st.cap_flag;
	end

	// State register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			st <= rst_state();
		else
			st <= nx;
	end

	assign rdata                  = st.rdata;
	assign calibration_output_pin = st.cal_out;
	assign alarm_out              = st.alarm_out;
	assign capture_irq            = st.irq;

endmodule // calendar_rtc_register_core

// ===== logic/rtc_pkg.sv
// Types shared by the calendar clock core
package rtc_pkg;

	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF   = 2'b01,
		KEY_OPEN   = 2'b10
	} key_state_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [22:0] time_v;
		logic [23:0] date_v;
		logic [22:0] psc;
		logic [31:0] alarm;
		logic [15:0] cal;
		logic [22:0] sh_time;
		logic [23:0] sh_date;
		logic [15:0] sh_sub;
		logic        half;
		logic [6:0]  apre_cnt;
		logic [15:0] sub;
		logic [14:0] shift_amt;
		logic        shift_plus;
		logic        fwd_pend;
		logic        bwd_pend;
		logic        init_req;
		logic        init_act;
		logic        alarm_wr;
		logic        adj_pend;
		logic        cal_set;
		logic        sh_sync;
		logic        alarm_flag;
		logic        al_prev;
		logic        cap_flag;
		logic        cap_ovr;
		logic        tamp_flag;
		logic        cal_pend;
		key_state_t  key;
		logic [2:0]  ts_sync;
		logic        ts_lvl;
		logic [2:0]  tp_sync;
		logic        tp_lvl;
		logic [22:0] cap_time;
		logic [31:0] rdata;
		logic        cal_out;
		logic        alarm_out;
		logic        irq;
	} rtc_state_t;

endpackage

// ===== logic/rtc_regs.svh
// Register map, field positions, reset values and key codes of the calendar clock core
// Summary of operation
// - Capture interrupt enable gates capture request
// - Hour forward step adds one hour
// - Hour backward step, ignored at hour zero
// - Daylight note bit is plain storage
// - Calibration pin carries 512Hz or 1Hz tap
// - Alarm pin source and polarity select
// - Status protected except event flag bits
// - Alarm writable flag follows alarm disable, cleared in init
// - Adjust pending set on shift write
// - Calendar set flag when year nonzero
// - Shadow sync flag on shadow copy
// - Init request halts counting, allows loading
// - Alarm match flag on unmasked match
// - Capture flag and overrun flag
// - Tamper flag on tamper event
// - Calibration pending locks calibration register
// - Prescaler written in init, two stages
// - Alarm writable when flag or init; masks
// - Weekday select compares day units to weekday
// - Key field always reads zero
// - Fraction counter exposes synchronous down counter
// - Shift adds delay and optional second
// - Capture time cleared with capture flag
// - Bypass select reads live counters
// - Alarm compare enable bit
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Byte offsets
`define OFS_TIME      8'h00
`define OFS_DATE      8'h04
`define OFS_CTRL      8'h08
`define OFS_STS       8'h0C
`define OFS_PSC       8'h10
`define OFS_ALARM     8'h1C
`define OFS_KEY       8'h24
`define OFS_FRAC      8'h28
`define OFS_SHIFT     8'h2C
`define OFS_CAPT      8'h30
`define OFS_CAL       8'h3C

// Control bit positions
`define CT_EDGE       3
`define CT_BYPASS     5
`define CT_ALR_EN     8
`define CT_TS_EN      11
`define CT_CAP_IE     15
`define CT_FWD        16
`define CT_BWD        17
`define CT_RATE       19
`define CT_POL        20
`define CT_SRC_HI     22
`define CT_SRC_LO     21
`define CT_CAL_EN     23
`define CT_WMASK      32'h00FC9978
`define CT_INIT_ONLY  32'h00000050

// Status bit positions
`define ST_INIT_REQ   7
`define ST_SYNC       5
`define ST_ALARM      8
`define ST_CAP        11
`define ST_OVR        12
`define ST_TAMP       13

// Alarm bit positions
`define AL_SEC_IGN    7
`define AL_MIN_IGN    15
`define AL_HR_IGN     23
`define AL_WDAY_SEL   30
`define AL_DAY_IGN    31

// Field masks and reset values
`define TIME_MASK     23'h7F7F7F
`define DATE_MASK     24'hFFFF3F
`define PSC_MASK      23'h7F7FFF
`define PSC_RST       23'h7F00FF
`define DATE_RST      24'h002101
`define ALARM_SRC_A   2'b01

// Unlock key bytes, values arbitrary
`define KEY_FIRST     8'h5A
`define KEY_SECOND    8'hA7

`endif

// ===== verif/calendar_rtc_register_core_test.sv
// Self-checking bench for the calendar clock core
`timescale 1ns/1ps
module calendar_rtc_register_core_test;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [31:0] rdata;
	logic        capture_pin = 1'b0;
	logic        tamper_pin = 1'b0;
	logic        calibration_output_pin;
	logic        alarm_out;
	logic        capture_irq;
	logic [31:0] rv;
	int          bad_count = 0;
	int          checks = 0;
	int          n;
	int          k;
	int          hi;
	int          ch;
	// Reset reads: address beside expected value
	logic [39:0] rows [0:9] = '{40'h0C00000007, 40'h10007F00FF, 40'h1C00000000,
		40'h2400000000, 40'h2C00000000, 40'h3000000000, 40'h0400002101,
		40'h0800000000, 40'h0000000000, 40'h5000000000};

	always #2 sys_clk = ~sys_clk;

	calendar_rtc_register_core dut (
		.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.capture_pin(capture_pin), .tamper_pin(tamper_pin),
		.calibration_output_pin(calibration_output_pin),
		.alarm_out(alarm_out), .capture_irq(capture_irq));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// One-cycle register strobes
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 rv = rdata;
	endtask

	// Bounded poll; running out ends the run
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		rd(a);
		for (k = 0; k < 64 && (rv & m) !== v; k++)
			rd(a);
		check("poll", rv & m, v);
		if ((rv & m) !== v)
			tally_and_finish();
	endtask

	task automatic meas();
		logic p;
		repeat (4) @(posedge sys_clk);
		hi = 0;
		ch = 0;
		p = calibration_output_pin;
		repeat (128) begin
			@(posedge sys_clk);
			#1 hi += calibration_output_pin;
			ch += (calibration_output_pin != p);
			p = calibration_output_pin;
		end
	endtask

	task automatic pulse();
		@(posedge sys_clk);
		capture_pin <= 1'b1;
		repeat (10) @(posedge sys_clk);
		capture_pin <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask

	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		for (n = 0; n < 10; n++) begin
			rd(rows[n][39:32]);
			check("reset read", rv, rows[n][31:0]);
		end
		$display("test reset done");
		// Locked writes ignored
		wr(8'h10, 32'h00030007);
		wr(8'h0C, 32'h00000080);
		rd(8'h10);
		check("locked psc", rv, 32'h007F00FF);
		rd(8'h0C);
		check("locked init", rv & 32'h80, 32'h0);
		// Unlock, calibration taps at default dividers
		wr(8'h24, 32'h0000005A);
		wr(8'h24, 32'h000000A7);
		wr(8'h08, 32'h00800000);
		meas();
		check("fast tap", hi, 32'h40);
		wr(8'h08, 32'h00880000);
		meas();
		check("slow tap", {31'h0, ch < 2}, 32'h1);
		$display("test calibration done");
		// Init mode, load and capture while frozen
		wr(8'h0C, 32'h00000080);
		poll(8'h0C, 32'h40, 32'h40);
		wr(8'h10, 32'h00030007);
		wr(8'h00, 32'h00235958);
		wr(8'h04, 32'h00012115);
		wr(8'h1C, 32'h80000000);
		wr(8'h08, 32'h00A58900);
		rd(8'h10);
		check("psc", rv, 32'h00030007);
		rd(8'h1C);
		check("alarm", rv, 32'h80000000);
		rd(8'h08);
		check("ctrl", rv, 32'h00A48900);
		rd(8'h0C);
		check("init flags", rv & 32'h11, 32'h10);
		pulse();
		check("irq", capture_irq, 1'b1);
		rd(8'h0C);
		check("capture", rv & 32'h1800, 32'h0800);
		pulse();
		rd(8'h0C);
		check("overrun", rv & 32'h1800, 32'h1800);
		rd(8'h30);
		check("capt time", rv, 32'h00235958);
		rd(8'h00);
		check("frozen", rv, 32'h00235958);
		wr(8'h0C, 32'h00003080);
		rd(8'h30);
		check("capt clr", rv, 32'h0);
		rd(8'h0C);
		check("ovr kept", rv & 32'h1800, 32'h1000);
		check("irq off", capture_irq, 1'b0);
		@(posedge sys_clk);
		tamper_pin <= 1'b1;
		repeat (8) @(posedge sys_clk);
		tamper_pin <= 1'b0;
		rd(8'h0C);
		check("tamper", rv & 32'h2000, 32'h2000);
		wr(8'h0C, 32'h0);
		rd(8'h0C);
		check("cleared", rv & 32'h3901, 32'h0);
		$display("test init and capture done");
		// Alarm at midnight, then locked flag clear
		for (k = 0; k < 300 && alarm_out !== 1'b1; k++)
			@(posedge sys_clk);
		check("alarm pin", alarm_out, 1'b1);
		if (alarm_out !== 1'b1)
			tally_and_finish();
		rd(8'h0C);
		check("alarm flag", rv & 32'h100, 32'h100);
		wr(8'h24, 32'h0);
		wr(8'h08, 32'h0);
		rd(8'h08);
		check("relocked", rv, 32'h00A48900);
		wr(8'h0C, 32'h00003800);
		rd(8'h0C);
		check("flag clr", rv & 32'h100, 32'h0);
		check("pin low", alarm_out, 1'b0);
		$display("test alarm done");
		// Hour steps, polarity, shift
		wr(8'h24, 32'h0000005A);
		wr(8'h24, 32'h000000A7);
		for (n = 0; n < 3; n++) begin
			wr(8'h08, n == 1 ? 32'h00A58900 : 32'h00A68900);
			repeat (40) @(posedge sys_clk);
			rd(8'h00);
			check("hour", rv & 32'h3F0000, n == 1 ? 32'h10000 : 32'h0);
		end
		wr(8'h08, 32'h00B48900);
		repeat (3) @(posedge sys_clk);
		check("polarity", alarm_out, 1'b1);
		wr(8'h2C, 32'h00000010);
		poll(8'h0C, 32'h8, 32'h0);
		rd(8'h28);
		check("delayed", {31'h0, rv[15:0] > 16'h0007}, 32'h1);
		poll(8'h0C, 32'h20, 32'h20);
		$display("test steps and shift done");
		tally_and_finish();
	end
endmodule // calendar_rtc_register_core_test

bind calendar_rtc_register_core rtc_core_props u_props (
	.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
	.capture_pin(capture_pin), .tamper_pin(tamper_pin),
	.calibration_output_pin(calibration_output_pin),
	.alarm_out(alarm_out), .capture_irq(capture_irq));

// ===== verif/rtc_core_props.sv
// Port checker for the calendar clock core
`timescale 1ns/1ps
module rtc_core_props (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [31:0] rdata,
	// Pins
	input  wire logic        capture_pin,
	input  wire logic        tamper_pin,
	input  wire logic        calibration_output_pin,
	input  wire logic        alarm_out,
	input  wire logic        capture_irq
);
	logic [3:0] since_r;
	logic [3:0] since_nxt;
	logic       pin_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	// Cycles since the capture pin last moved, saturating
	always_comb begin
		since_nxt = (since_r == 4'hF) ? since_r : since_r + 4'h1;
		if (capture_pin != pin_r)
			since_nxt = 4'h0;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			since_r <= 4'hF;
			pin_r   <= 1'b0;
		end else begin
			since_r <= since_nxt;
			pin_r   <= capture_pin;
		end
	end

	property p_key_zero;
		rd_stb && addr == 8'h24 |=> rdata == 32'h0;
	endproperty
	a_key_zero: assert property (p_key_zero) else $error("key field read nonzero");

	property p_shift_zero;
		rd_stb && addr == 8'h2C |=> rdata == 32'h0;
	endproperty
	a_shift_zero: assert property (p_shift_zero) else $error("shift read nonzero");

	property p_step_bits;
		rd_stb && addr == 8'h08 |=> rdata[17:16] == 2'b00;
	endproperty
	a_step_bits: assert property (p_step_bits) else $error("hour step bits read set");

	property p_frac_width;
		rd_stb && addr == 8'h28 |=> rdata[31:16] == 16'h0;
	endproperty
	a_frac_width: assert property (p_frac_width) else $error("fraction upper bits set");

	property p_capt_bcd;
		rd_stb && addr == 8'h30 |=> rdata[31:23] == 9'h0 && !rdata[7] && rdata[6:4] <= 3'h5;
	endproperty
	a_capt_bcd: assert property (p_capt_bcd) else $error("capture seconds not bcd");

	property p_sts_fixed;
		rd_stb && addr == 8'h0C |=> rdata[2:1] == 2'b11 && rdata[31:17] == 15'h0;
	endproperty
	a_sts_fixed: assert property (p_sts_fixed) else $error("status fixed bits wrong");

	property p_irq_cause;
		$rose(capture_irq) |-> since_r <= 4'h9;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("capture request without edge");

	property p_out_reset;
		$fell(reset) |-> !alarm_out && !capture_irq && !calibration_output_pin;
	endproperty
	a_out_reset: assert property (p_out_reset) else $error("pins active after reset");

	c_irq: cover property ($rose(capture_irq));
	c_alarm: cover property ($rose(alarm_out));
	c_cal: cover property ($rose(calibration_output_pin));
endmodule // rtc_core_props
